/* verilog/frs_pkg.sv */
// Constants for the flash reset and sleep command block.
// Assumes a 100 MHz core clock and a separate serial link clock.
package frs_pkg;
    // ********************************
    // Instruction codes
    // ********************************
    localparam logic [7:0] CMD_RESTART_ARM = 8'h66;
    localparam logic [7:0] CMD_RESTART = 8'h99;
    localparam logic [7:0] CMD_LEGACY_RESTART = 8'hf0;
    localparam logic [7:0] CMD_MODE_BITS_CLEAR = 8'hff;
    localparam logic [7:0] CMD_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] CMD_WAKE = 8'hab;

    // ********************************
    // Field positions
    // ********************************
    localparam int FREEZE_BIT = 0;
    localparam int WIP_BIT = 0;
    localparam int LEGACY_EN_BIT = 0;
    localparam int BP_LSB = 2;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESTART_RECOVERY_NS = 35000;
    localparam int POWERUP_NS = 300000;
    localparam int SLEEP_ENTRY_NS = 3000;
    localparam int WAKE_NS = 30000;
    localparam int RESTART_RECOVERY_CYC = (RESTART_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 20;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] VCFG1_RESET = 8'h00;
    localparam logic [7:0] VSTAT1_RESET = 8'h00;
    localparam logic [7:0] VCFG3_RESET = 8'h00;
    localparam logic SGUARD_RESET = 1'b1;
endpackage

/* verilog/frs_link_rx.sv */
// Serial link receiver: shifts instruction bytes in on the link clock.
// Assumes sck_i is a clock port, stopped outside frames; cs_n_i is async.
`timescale 1ns/1ns
module frs_link_rx (
    // Link
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    input wire logic quad_i,
    // Captured byte, held steady until the next byte completes
    output logic [7:0] byte_o,
    output logic byte_tgl_o,
    output logic [3:0] cnt_o
);
    logic [7:0] shift;
    logic [3:0] cnt;

    // ********************************
    // Shifter
    // ********************************
    // The bit counter is cleared asynchronously by chip select so that no
    // clock edge is needed after a frame ends.
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            cnt <= 4'h0;
        end else if (quad_i) begin
            // Counts bits, so a full byte reads 8 in either mode
            cnt <= (cnt < 4'h9) ? cnt + 4'h4 : cnt;
        end else begin
            cnt <= (cnt < 4'h9) ? cnt + 4'h1 : cnt;
        end
    end

    always_ff @(posedge sck_i) begin
        if (quad_i) begin
            shift <= {shift[3:0], io_i};
        end else begin
            shift <= {shift[6:0], io_i[0]};
        end
    end

    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            byte_tgl_o <= 1'b0;
        end else if ((quad_i && cnt == 4'h4) || (!quad_i && cnt == 4'h7)) begin
            byte_tgl_o <= 1'b1;
        end
    end

    always_ff @(posedge sck_i) begin
        if (quad_i && cnt == 4'h4) begin
            byte_o <= {shift[3:0], io_i};
        end else if (!quad_i && cnt == 4'h7) begin
            byte_o <= {shift[6:0], io_i[0]};
        end
    end

    assign cnt_o = cnt;
endmodule

/* verilog/frs_core.sv */
// Reset, mode-bits clear and deep sleep command handling of a serial flash.
// Assumes a 100 MHz core clock and a host-driven link clock on sck_i.
`timescale 1ns/1ns
module frs_core #(
    parameter int RESTART_CYC = frs_pkg::RESTART_RECOVERY_CYC,
    parameter int POWERUP_CYC = frs_pkg::POWERUP_CYC,
    parameter int WAKE_CYC = frs_pkg::WAKE_CYC
) (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Serial link
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_o,
    // Mode and state inputs
    input wire logic quad_mode_i,
    input wire logic powerup_fail_i,
    input wire logic write_in_progress_flag_i,
    input wire logic freeze_set_i,
    input wire logic sector_guard_clear_i,
    input wire logic continuous_read_set_i,
    input wire logic [7:0] nv_config_one_i,
    input wire logic [7:0] nv_status_one_i,
    input wire logic [7:0] nv_config_three_i,
    // Status outputs
    output logic [7:0] volatile_config_one_o,
    output logic [7:0] volatile_status_one_o,
    output logic [7:0] volatile_config_three_o,
    output logic [7:0] nonvolatile_config_one_o,
    output logic sector_guard_lock_bit_o,
    output logic continuous_read_o,
    output logic deep_sleep_o,
    output logic busy_o,
    output logic restart_arm_o,
    output logic restart_pulse_o
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RESTART = 5'b00010,
        ST_SLEEP_ENTRY = 5'b00100,
        ST_SLEEP = 5'b01000,
        ST_WAKE = 5'b10000
    } frs_state_t;

    // ********************************
    // Link receiver and crossings
    // ********************************
    logic [7:0] link_byte;
    logic link_tgl;
    logic [3:0] link_cnt;
    logic quad_link;

    frs_link_rx u_rx (
        .sck_i(sck_i),
        .cs_n_i(cs_n_i),
        .io_i(io_i),
        .quad_i(quad_link),
        .byte_o(link_byte),
        .byte_tgl_o(link_tgl),
        .cnt_o(link_cnt)
    );

    // Link count longer than one byte means chip select was late
    logic long_link;
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            long_link <= 1'b0;
        end else if (link_cnt >= 4'h8) begin
            long_link <= 1'b1;
        end
    end

    logic cs_s1, cs_s2, cs_s3;
    logic tgl_s1, tgl_s2, tgl_s3;
    logic long_s1, long_s2, long_s3;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
            long_s1 <= 1'b0;
            long_s2 <= 1'b0;
            long_s3 <= 1'b0;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            tgl_s1 <= link_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
            long_s1 <= long_link;
            long_s2 <= long_s1;
            long_s3 <= long_s2;
        end
    end

    // Mode is copied only while no frame runs, so the link side sees one value
    // for a whole frame; a copy on the link clock would lag, as it stops idle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            quad_link <= 1'b0;
        end else if (cs_s2) begin
            quad_link <= quad_mode_i;
        end
    end

    // Link flags are wiped when chip select rises, so their verdict is taken
    // from a stage older than the chip select copy that still reads low
    logic frame_good;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            frame_good <= 1'b0;
        end else if (!cs_s2) begin
            frame_good <= tgl_s3 && !long_s3;
        end
    end

    // Byte is stable once chip select is seen high here
    logic frame_end;
    logic frame_ok;
    assign frame_end = cs_s2 && !cs_s3;
    assign frame_ok = frame_end && frame_good;

    logic [7:0] cmd;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmd <= 8'h00;
        end else if (cs_s2 && !cs_s3) begin
            cmd <= link_byte;
        end
    end

    logic cmd_valid;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= frame_ok;
        end
    end

    // ********************************
    // Command sequencer
    // ********************************
    frs_state_t state;
    frs_state_t next_state;
    logic [frs_pkg::TIMER_W-1:0] timer;
    logic [frs_pkg::TIMER_W-1:0] next_timer;
    logic do_restart;
    logic awake;

    assign awake = (state == ST_IDLE);

    // The legacy restart is honoured only with its enable bit set
    assign do_restart = cmd_valid && awake &&
        ((cmd == frs_pkg::CMD_RESTART && restart_arm_o) ||
         (cmd == frs_pkg::CMD_LEGACY_RESTART &&
          volatile_config_three_o[frs_pkg::LEGACY_EN_BIT]));

    always_comb begin
        next_state = state;
        next_timer = timer;
        case (state)
            ST_IDLE: begin
                if (do_restart) begin
                    next_state = ST_RESTART;
                    next_timer = powerup_fail_i ?
                        frs_pkg::TIMER_W'(POWERUP_CYC - 1) :
                        frs_pkg::TIMER_W'(RESTART_CYC - 1);
                end else if (cmd_valid && cmd == frs_pkg::CMD_DEEP_SLEEP &&
                             !write_in_progress_flag_i) begin
                    next_state = ST_SLEEP_ENTRY;
                    next_timer = frs_pkg::TIMER_W'(frs_pkg::SLEEP_ENTRY_CYC - 1);
                end
            end
            ST_RESTART, ST_SLEEP_ENTRY: begin
                if (timer == '0) begin
                    next_state = (state == ST_RESTART) ? ST_IDLE : ST_SLEEP;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            ST_SLEEP: begin
                // Everything but wake is dropped here
                if (cmd_valid && cmd == frs_pkg::CMD_WAKE) begin
                    next_state = ST_WAKE;
                    next_timer = frs_pkg::TIMER_W'(WAKE_CYC - 1);
                end
            end
            ST_WAKE: begin
                if (timer == '0) begin
                    next_state = ST_IDLE;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // ********************************
    // Restart arm and mode bits
    // ********************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            restart_arm_o <= 1'b0;
        end else if (cmd_valid && awake) begin
            restart_arm_o <= (cmd == frs_pkg::CMD_RESTART_ARM);
        end else if (frame_end && !frame_ok && awake) begin
            restart_arm_o <= 1'b0;
        end
    end

    // Continuous read is entered by read logic outside this block
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            continuous_read_o <= 1'b0;
        end else if (continuous_read_set_i) begin
            continuous_read_o <= 1'b1;
        end else if (cmd_valid && cmd == frs_pkg::CMD_MODE_BITS_CLEAR && awake) begin
            continuous_read_o <= 1'b0;
        end else if (do_restart) begin
            continuous_read_o <= 1'b0;
        end
    end

    // ********************************
    // Volatile registers
    // ********************************
    logic freeze;
    assign freeze = volatile_config_one_o[frs_pkg::FREEZE_BIT];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            volatile_config_one_o <= frs_pkg::VCFG1_RESET;
            volatile_config_three_o <= frs_pkg::VCFG3_RESET;
            nonvolatile_config_one_o <= nv_config_one_i;
            sector_guard_lock_bit_o <= frs_pkg::SGUARD_RESET;
        end else if (do_restart) begin
            // Freeze is kept; config one bits 7:1 and config three reload from nonvolatile copies, guard and nv config stay
            // A freeze request in the same cycle still lands
            volatile_config_one_o <= {nv_config_one_i[7:1], freeze | freeze_set_i};
            volatile_config_three_o <= nv_config_three_i;
            nonvolatile_config_one_o <= nonvolatile_config_one_o;
        end else begin
            if (freeze_set_i) begin
                volatile_config_one_o[frs_pkg::FREEZE_BIT] <= 1'b1;
            end
            if (sector_guard_clear_i) begin
                sector_guard_lock_bit_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            volatile_status_one_o <= frs_pkg::VSTAT1_RESET;
        end else if (do_restart) begin
            volatile_status_one_o[1:0] <= nv_status_one_i[1:0];
            volatile_status_one_o[7:5] <= nv_status_one_i[7:5];
            if (!freeze) begin
                volatile_status_one_o[frs_pkg::BP_LSB+:3] <=
                    nv_status_one_i[frs_pkg::BP_LSB+:3];
            end
        end else begin
            volatile_status_one_o[frs_pkg::WIP_BIT] <= write_in_progress_flag_i;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // No data is returned: wake gives no identification, so pins stay off
    assign io_o = 4'h0;
    assign io_oe_o = 4'h0;
    assign deep_sleep_o = (state == ST_SLEEP) || (state == ST_SLEEP_ENTRY);
    assign busy_o = !awake;
    assign restart_pulse_o = do_restart;

    // ********************************
    // Checks
    // ********************************
    chk_restart_keeps_freeze: assert property (@(posedge clk_i) disable iff (srst_i)
        do_restart |=> volatile_config_one_o[0] == $past(freeze || freeze_set_i))
        else $error("freeze changed by restart");
    chk_guard_kept: assert property (@(posedge clk_i) disable iff (srst_i)
        do_restart |=> $stable(sector_guard_lock_bit_o))
        else $error("guard lock changed by restart");
    chk_nv_kept: assert property (@(posedge clk_i) disable iff (srst_i)
        do_restart |=> $stable(nonvolatile_config_one_o))
        else $error("nv config changed");
    chk_bp_frozen: assert property (@(posedge clk_i) disable iff (srst_i)
        do_restart && freeze |=> $stable(volatile_status_one_o[4:2]))
        else $error("protect bits changed while frozen");
    chk_restart_busy: assert property (@(posedge clk_i) disable iff (srst_i)
        do_restart |=> state == ST_RESTART [*8])
        else $error("restart recovery too short");
    chk_sleep_idle_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        cmd_valid && awake && cmd == frs_pkg::CMD_DEEP_SLEEP && write_in_progress_flag_i
        |=> state == ST_IDLE)
        else $error("sleep taken while busy");
    chk_sleep_ignores: assert property (@(posedge clk_i) disable iff (srst_i)
        state == ST_SLEEP && !(cmd_valid && cmd == frs_pkg::CMD_WAKE)
        |=> state == ST_SLEEP)
        else $error("sleep left without wake");
    chk_arm_cleared: assert property (@(posedge clk_i) disable iff (srst_i)
        cmd_valid && awake && cmd != frs_pkg::CMD_RESTART_ARM |=> !restart_arm_o)
        else $error("arm not cleared");
    chk_legacy_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        cmd_valid && cmd == frs_pkg::CMD_LEGACY_RESTART && !volatile_config_three_o[0]
        |-> !do_restart)
        else $error("legacy restart while disabled");

    cov_restart: cover property (@(posedge clk_i) disable iff (srst_i) do_restart);
    cov_sleep: cover property (@(posedge clk_i) disable iff (srst_i)
        state == ST_SLEEP_ENTRY ##1 state == ST_SLEEP);
    cov_wake: cover property (@(posedge clk_i) disable iff (srst_i)
        state == ST_WAKE ##1 state == ST_IDLE);
    cov_clear: cover property (@(posedge clk_i) disable iff (srst_i)
        cmd_valid && cmd == frs_pkg::CMD_MODE_BITS_CLEAR);
endmodule

/* sim/frs_host_model.sv */
// Host side of the serial link: one instruction byte per chip-select frame.
// Assumes the bench calls send only between frames; the link clock idles low.
`timescale 1ns/1ns
module frs_host_model (
    // Link to the device
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] io_o
);
    // ********************************
    // Framing
    // ********************************
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
    end

    // Edge counts other than 8 (2 in quad) give a malformed frame on purpose
    task automatic send(input logic [7:0] b, input logic quad, input int edges);
        int i;
        int n;
        n = (edges == 0) ? (quad ? 2 : 8) : edges;
        #7;
        cs_n_o = 1'b0;
        for (i = 0; i < n; i++) begin
            if (quad) begin
                io_o = (i % 2 == 0) ? b[7:4] : b[3:0];
            end else begin
                io_o = {3'($urandom), b[7 - i % 8]};
            end
            #62 sck_o = 1'b1;
            #63 sck_o = 1'b0;
        end
        // Chip select rises right after the last bit; lines then show no stale value
        #40 cs_n_o = 1'b1;
        io_o = ~io_o;
    endtask
endmodule

/* sim/test_flash_reset_and_sleep_cmds.sv */
// Self-checking bench for the restart, mode-bit clear and deep sleep commands.
// Assumes the host model drives the link; core inputs change at the falling clock edge.
`timescale 1ns/1ns
module test_flash_reset_and_sleep_cmds;
    // ********************************
    // Signals
    // ********************************
    localparam int RST_CYC = 20;
    localparam int PU_CYC = 60;
    localparam int WK_CYC = 30;
    localparam logic [7:0] ARM = frs_pkg::CMD_RESTART_ARM;
    localparam logic [7:0] RST = frs_pkg::CMD_RESTART;
    localparam logic [7:0] WAKE = frs_pkg::CMD_WAKE;
    localparam logic [7:0] SLEEP = frs_pkg::CMD_DEEP_SLEEP;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic quad = 1'b0;
    logic pu_fail = 1'b0;
    logic write_in_progress_flag = 1'b0;
    logic frz_set = 1'b0;
    logic grd_clr = 1'b0;
    logic rd_set = 1'b0;
    logic [7:0] nv_c1 = 8'h00;
    logic [7:0] nv_s1 = 8'h00;
    logic [7:0] nv_c3 = 8'h00;
    logic sck, cs_n, grd, cont_rd, sleep, busy, arm, pulse, saw_pulse, p_grd;
    logic [3:0] io, dout, doe;
    logic [7:0] vc1, vs1, vc3, nvc1, p_c1, p_s1, p_nv, e_s1;
    int err_count = 0;
    int samples_checked = 0;
    int busy_cyc;
    int k;

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    frs_host_model frs_host_model_inst (.sck_o(sck), .cs_n_o(cs_n), .io_o(io));

    frs_core #(.RESTART_CYC(RST_CYC), .POWERUP_CYC(PU_CYC), .WAKE_CYC(WK_CYC)) frs_core_inst (
        .clk_i(clk_i), .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(io), .io_o(dout),
        .io_oe_o(doe), .quad_mode_i(quad), .powerup_fail_i(pu_fail),
        .write_in_progress_flag_i(write_in_progress_flag), .freeze_set_i(frz_set), .sector_guard_clear_i(grd_clr),
        .continuous_read_set_i(rd_set),
        .nv_config_one_i(nv_c1), .nv_status_one_i(nv_s1), .nv_config_three_i(nv_c3),
        .volatile_config_one_o(vc1), .volatile_status_one_o(vs1), .volatile_config_three_o(vc3),
        .nonvolatile_config_one_o(nvc1), .sector_guard_lock_bit_o(grd),
        .continuous_read_o(cont_rd), .deep_sleep_o(sleep), .busy_o(busy),
        .restart_arm_o(arm), .restart_pulse_o(pulse));

    // ********************************
    // Tasks
    // ********************************
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        check(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic hard_reset();
        @(negedge clk_i);
        srst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        srst_i = 1'b0;
        repeat (5) @(negedge clk_i);
    endtask

    // One frame, then watch until the device settles; cs stays high all that time
    task automatic cmd(input logic [7:0] b, input int edges);
        int i;
        frs_host_model_inst.send(b, quad, edges);
        saw_pulse = 1'b0;
        busy_cyc = 0;
        for (i = 0; i < 4000; i++) begin
            @(negedge clk_i);
            if (pulse === 1'b1) saw_pulse = 1'b1;
            if (busy === 1'b1 && sleep !== 1'b1) busy_cyc++;
            if (i >= 8 && (busy !== 1'b1 || sleep === 1'b1)) break;
        end
        if (i == 4000) begin
            err_count++;
            $display("unexpected busy: expected 0, seen 1");
            summarize();
        end
        repeat (2) @(negedge clk_i);
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        void'($urandom(35452));
        hard_reset();
        chk1("deep sleep", 1'b0, sleep);
        chk1("guard lock", 1'b1, grd);
        check("config one", 8'h00, vc1);
        chk1("busy", 1'b0, busy);
        $display("test reset done");
        for (k = 0; k < 6; k++) begin
            if (k == 5) begin
                hard_reset();
                chk1("freeze after reset", 1'b0, vc1[0]);
                chk1("guard after reset", 1'b1, grd);
            end
            quad = k[0];
            pu_fail = (k == 4);
            nv_c1 = 8'($urandom);
            nv_s1 = 8'($urandom);
            nv_c3 = {7'($urandom), k[1]};
            frz_set = (k == 2);
            grd_clr = (k == 3);
            rd_set = 1'b1;
            @(negedge clk_i);
            frz_set = 1'b0;
            grd_clr = 1'b0;
            rd_set = 1'b0;
            @(negedge clk_i);
            p_c1 = vc1;
            p_s1 = vs1;
            p_grd = grd;
            p_nv = nvc1;
            chk1("continuous read set", 1'b1, cont_rd);
            cmd(frs_pkg::CMD_MODE_BITS_CLEAR, 0);
            chk1("continuous read", 1'b0, cont_rd);
            cmd(ARM, 0);
            chk1("armed", 1'b1, arm);
            cmd(RST, 0);
            chk1("restart pulse", 1'b1, saw_pulse);
            chk1("restart length", 1'b1, busy_cyc >= (k == 4 ? PU_CYC : RST_CYC) &&
                busy_cyc <= (k == 4 ? PU_CYC : RST_CYC) + 2);
            // Freeze keeps the protect levels; status bit 0 follows the busy input
            e_s1 = nv_s1;
            if (p_c1[0]) e_s1[4:2] = p_s1[4:2];
            e_s1[0] = write_in_progress_flag;
            check("config one", {nv_c1[7:1], p_c1[0]}, vc1);
            check("status one", e_s1, vs1);
            check("config three", nv_c3, vc3);
            chk1("guard kept", p_grd, grd);
            check("nonvolatile config", p_nv, nvc1);
            cmd(frs_pkg::CMD_LEGACY_RESTART, 0);
            chk1("legacy restart", nv_c3[0], saw_pulse);
        end
        $display("test restart done");
        quad = 1'b0;
        pu_fail = 1'b0;
        cmd(RST, 0);
        chk1("restart without arm", 1'b0, saw_pulse);
        for (k = 0; k < 3; k++) begin
            cmd(ARM, 0);
            cmd(k == 0 ? WAKE : RST, k == 0 ? 8 : 5 + 2 * k);
            chk1("arm after other", 1'b0, arm);
            cmd(RST, 0);
            chk1("disarmed restart", 1'b0, saw_pulse);
        end
        $display("test disarm done");
        write_in_progress_flag = 1'b1;
        cmd(SLEEP, 0);
        chk1("sleep while writing", 1'b0, sleep);
        write_in_progress_flag = 1'b0;
        cmd(SLEEP, 9);
        chk1("sleep long frame", 1'b0, sleep);
        cmd(SLEEP, 0);
        repeat (310) @(negedge clk_i);
        chk1("asleep", 1'b1, sleep);
        cmd(ARM, 0);
        chk1("arm while asleep", 1'b0, arm);
        cmd(WAKE, 0);
        chk1("woken", 1'b0, sleep);
        chk1("wake length", 1'b1, busy_cyc >= WK_CYC && busy_cyc <= WK_CYC + 2);
        check("data lines", 8'h00, {dout, doe});
        quad = 1'b1;
        cmd(SLEEP, 0);
        chk1("asleep quad", 1'b1, sleep);
        hard_reset();
        chk1("sleep after reset", 1'b0, sleep);
        $display("test sleep done");
        summarize();
    end
endmodule
